// [csp_pkg.sv]
// Constants and types of the clock source, start-up and prescaler block.
// Assumes one 20 MHz source clock and static fuse inputs.
//
// Notes on behaviour
// [R01] Source select 0100 picks the 32.768 kHz watch crystal.
// [R02] Watch crystal start-up: 1024 or 32768 cycles, plus 4 or 64 ms.
// [R03] Crystal source: upper three select bits give the oscillator mode.
// [R04] Crystal wake delay: 258, 1024 or 16384 cycles by range bit and delay.
// [R05] Crystal reset delay: 14 cycles plus 0, 4 or 64 ms.
// [R06] Shipped fuses: internal 8 MHz, longest delay, divide by eight.
// [R07] The prescaler serves every source and all synchronous clock domains.
// [R08] Divider changes never produce a period shorter than old and new.
// [R09] The prescaler counts on the source clock; its count is hidden.
// [R10] New rate holds after one old plus one or two new periods.
// [R11] Clock-out fuse drives system clock on the pin, never in reset.
// [R12] No clock output while the crystal oscillator uses the crystal pins.
// [R13] The clock-out pin carries the divided clock.
// [R14] Trim register loads the factory value at reset; software may rewrite.
// [R15] Trim top bit selects low or high frequency range.
// [R16] Lower seven trim bits tune frequency upward within the range.
// [R17] Software keeps the trim below 8.8 MHz when writing memories.
// [R18] Unlock bit sets only when written one with all other bits zero.
// [R19] Unlock clears after four cycles or a divider write; rewrite is inert.
// [R20] Software writes unlock, then the divider within four cycles.
// [R21] Divider select 0 to 8 divides by 1 to 256; 9 to 15 reserved.
// [R22] Divider select resets to 3 with divide-by-eight fuse, else 0.
// [R23] Fuses are static; start-up counters count source cycles.

package csp_pkg;

  localparam int CLK_PERIOD_NS = 50;
  localparam int DELAY_SHORT_MS = 4;
  localparam int DELAY_LONG_MS = 64;
  localparam int DELAY_SHORT_CYC = DELAY_SHORT_MS * 1000000 / CLK_PERIOD_NS;
  localparam int DELAY_LONG_CYC = DELAY_LONG_MS * 1000000 / CLK_PERIOD_NS;

  // Start-up counts in source cycles (6, 14, 258, 1K, 16K, 32K)
  localparam logic [23:0] CK_WAKE_RC = 24'h000006;
  localparam logic [23:0] CK_RST_BASE = 24'h00000E;
  localparam logic [23:0] CK_258 = 24'h000102;
  localparam logic [23:0] CK_1K = 24'h000400;
  localparam logic [23:0] CK_16K = 24'h004000;
  localparam logic [23:0] CK_32K = 24'h008000;

  localparam logic [2:0] UNLOCK_CYC = 3'h4;

  localparam int ADDR_W = 12;
  localparam logic [7:0] IDX_DIV = 8'h30;
  localparam logic [7:0] IDX_TRIM = 8'h31;
  localparam logic [7:0] IDX_STAT = 8'h32;
  localparam logic [11:0] ADDR_DIV = {2'h0, IDX_DIV, 2'h0};
  localparam logic [11:0] ADDR_TRIM = {2'h0, IDX_TRIM, 2'h0};
  localparam logic [11:0] ADDR_STAT = {2'h0, IDX_STAT, 2'h0};

  localparam int UNLOCK_BIT = 7;
  localparam logic [7:0] UNLOCK_WORD = 8'h80;
  localparam logic [3:0] DIV_RST_DIV8 = 4'h3;
  localparam logic [3:0] DIV_RST_NODIV = 4'h0;
  localparam logic [3:0] DIV_SEL_MAX = 4'h8;

  localparam logic [3:0] SRC_EXT = 4'h0;
  localparam logic [3:0] SRC_PLL = 4'h1;
  localparam logic [3:0] SRC_RC8M = 4'h2;
  localparam logic [3:0] SRC_RC128K = 4'h3;
  localparam logic [3:0] SRC_LFXT = 4'h4;

  typedef struct packed {
    logic [3:0] clock_source_select;
    logic [1:0] startup_delay_select;
    logic initial_divide_by_eight;
    logic clock_out_fuse;
  } csp_fuse_t;

  // Shipped setting; clock-out fuse left unprogrammed [R06]
  localparam csp_fuse_t FUSE_SHIPPED = '{4'h2, 2'h2, 1'b1, 1'b0};

  typedef enum logic [1:0] {
    ST_RST_WAIT = 2'b00,
    ST_RUN = 2'b01,
    ST_SLEEP = 2'b10,
    ST_WAKE_WAIT = 2'b11
  } csp_state_t;

endpackage

// [csp_clock_ctrl.sv]
// Clock source decode, start-up delay, glitch-free prescaler, clock-out
// pin and oscillator trim, with an APB register slave.
// Assumes fuses are static and the APB master runs on ref_clk_in.
//
// Added by the designer: the APB register port.
`timescale 1ns/1ps

module csp_clock_ctrl #(
  parameter int DELAY_SHORT_CYC_P = csp_pkg::DELAY_SHORT_CYC,
  parameter int DELAY_LONG_CYC_P = csp_pkg::DELAY_LONG_CYC
) (
  input wire logic ref_clk_in, // Undivided source clock
  input wire logic reset_in, // Async reset, active high
  input wire logic clk_en_in, // Freezes all state when low
  input wire csp_pkg::csp_fuse_t fuse_in, // Static fuse settings
  input wire logic [7:0] factory_trim_in, // Calibration byte
  input wire logic power_down_in, // Sleep request level
  input wire logic psel, // APB select
  input wire logic penable, // APB enable
  input wire logic pwrite, // APB direction
  input wire logic [11:0] paddr, // APB byte address
  input wire logic [31:0] pwdata, // APB write data
  output logic [31:0] prdata, // APB read data
  output logic pready, // APB ready
  output logic pslverr, // APB error
  output logic sys_clk_en_out, // One pulse per system clock
  output logic clock_ready_out, // Start-up done, running
  output logic clock_out_pin_out, // Clock-out pin level
  output logic clock_out_pin_oe_out, // Clock-out pin enable
  output logic [7:0] trim_out, // Trim to the RC oscillator
  output logic [2:0] osc_mode_out, // Crystal oscillator mode
  output logic lf_crystal_sel_out, // Watch crystal selected
  output logic crystal_sel_out // Crystal/resonator selected
);

  ////////////////////////////////////////////////////////////////////////////
  // Start-up delay decode

  function automatic logic [23:0] wake_ck(input csp_pkg::csp_fuse_t f);
    logic [2:0] xi;
    logic [23:0] s;
    logic [23:0] l;
    xi = {f.clock_source_select[0], f.startup_delay_select};
    s = 24'(DELAY_SHORT_CYC_P);
    l = 24'(DELAY_LONG_CYC_P);
    wake_ck = csp_pkg::CK_WAKE_RC;
    if (f.clock_source_select[3]) begin
      if (xi <= 3'h1) begin // [R04]
        wake_ck = csp_pkg::CK_258;
      end else if (xi <= 3'h4) begin
        wake_ck = csp_pkg::CK_1K;
      end else begin
        wake_ck = csp_pkg::CK_16K;
      end
    end else if (f.clock_source_select == csp_pkg::SRC_LFXT) begin
      if (f.startup_delay_select[1]) begin // [R02]
        wake_ck = csp_pkg::CK_32K;
      end else begin
        wake_ck = csp_pkg::CK_1K;
      end
    end else if (f.clock_source_select == csp_pkg::SRC_PLL) begin
      wake_ck = csp_pkg::CK_RST_BASE;
      wake_ck = wake_ck + (f.startup_delay_select[0] ?
                           csp_pkg::CK_16K : csp_pkg::CK_1K);
      wake_ck = wake_ck + (f.startup_delay_select[1] ? l : s);
    end
  endfunction

  function automatic logic [23:0] reset_ck(input csp_pkg::csp_fuse_t f);
    logic [2:0] xi;
    logic [23:0] s;
    logic [23:0] l;
    logic [23:0] ms;
    xi = {f.clock_source_select[0], f.startup_delay_select};
    s = 24'(DELAY_SHORT_CYC_P);
    l = 24'(DELAY_LONG_CYC_P);
    ms = l;
    reset_ck = wake_ck(f);
    if (f.clock_source_select[3]) begin
      case (xi) // [R05]
        3'h0, 3'h3, 3'h6: ms = s;
        3'h2, 3'h5: ms = 24'h000000;
        default: ms = l;
      endcase
      reset_ck = reset_ck + csp_pkg::CK_RST_BASE + ms;
    end else if (f.clock_source_select == csp_pkg::SRC_LFXT) begin
      ms = (f.startup_delay_select == 2'h0) ? s : l; // [R02]
      reset_ck = reset_ck + ms;
    end else if (f.clock_source_select == csp_pkg::SRC_PLL) begin
      reset_ck = reset_ck + s;
    end else begin
      case (f.startup_delay_select)
        2'h0: ms = 24'h000000;
        2'h1: ms = s;
        default: ms = l;
      endcase
      reset_ck = reset_ck + csp_pkg::CK_RST_BASE + ms;
    end
  endfunction

  function automatic logic [7:0] div_last(input logic [3:0] sel);
    if (sel > csp_pkg::DIV_SEL_MAX) begin
      div_last = 8'hFF;
    end else begin
      div_last = 8'((9'h001 << sel) - 9'h001); // [R21]
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Signals

  csp_pkg::csp_state_t state_reg;
  logic [23:0] dly_cnt_reg;
  logic init_done_reg;
  logic [7:0] trim_reg;
  logic [3:0] divider_select_reg;
  logic unlock_reg;
  logic [2:0] unlock_cnt_reg;
  logic [7:0] cnt_reg;
  logic [3:0] act_sel_reg;
  logic sw_pend_reg;
  logic sw_busy_reg;
  logic [23:0] dly_target;
  logic tick_now;
  logic run;
  logic setup;
  logic wr_acc;
  logic wr_div;
  logic src_is_xt;
  logic src_is_lf;

  assign setup = psel && !penable;
  assign wr_acc = psel && penable && pwrite && pready;
  assign wr_div = wr_acc && (paddr == csp_pkg::ADDR_DIV);
  assign run = (state_reg == csp_pkg::ST_RUN);
  assign tick_now = (cnt_reg == div_last(act_sel_reg));
  // Static fuses are read directly [R23]
  assign src_is_xt = fuse_in.clock_source_select[3];
  assign src_is_lf = (fuse_in.clock_source_select == csp_pkg::SRC_LFXT);
  assign dly_target = (state_reg == csp_pkg::ST_RST_WAIT) ?
                      reset_ck(fuse_in) : wake_ck(fuse_in);

  ////////////////////////////////////////////////////////////////////////////
  // Start-up sequencing

  always_ff @(posedge ref_clk_in or posedge reset_in) begin
    if (reset_in) begin
      state_reg <= csp_pkg::ST_RST_WAIT;
      dly_cnt_reg <= 24'h000000;
    end else if (clk_en_in) begin
      case (state_reg)
        csp_pkg::ST_RST_WAIT, csp_pkg::ST_WAKE_WAIT: begin
          if (dly_cnt_reg >= dly_target - 24'h000001) begin // [R23]
            state_reg <= csp_pkg::ST_RUN;
            dly_cnt_reg <= 24'h000000;
          end else begin
            dly_cnt_reg <= dly_cnt_reg + 24'h000001;
          end
        end
        csp_pkg::ST_RUN: begin
          if (power_down_in) begin
            state_reg <= csp_pkg::ST_SLEEP;
          end
        end
        csp_pkg::ST_SLEEP: begin
          if (!power_down_in) begin
            state_reg <= csp_pkg::ST_WAKE_WAIT;
            dly_cnt_reg <= 24'h000000;
          end
        end
        default: state_reg <= csp_pkg::ST_RST_WAIT;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Reset-time loads and trim

  always_ff @(posedge ref_clk_in or posedge reset_in) begin
    if (reset_in) begin
      init_done_reg <= 1'b0;
      trim_reg <= 8'h00;
    end else if (clk_en_in) begin
      init_done_reg <= 1'b1;
      if (!init_done_reg) begin
        trim_reg <= factory_trim_in; // [R14]
      end else if (wr_acc && paddr == csp_pkg::ADDR_TRIM) begin
        trim_reg <= pwdata[7:0]; // [R14] [R15] [R16]
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Divider control with unlock window

  always_ff @(posedge ref_clk_in or posedge reset_in) begin
    if (reset_in) begin
      divider_select_reg <= csp_pkg::DIV_RST_NODIV;
      unlock_reg <= 1'b0;
      unlock_cnt_reg <= 3'h0;
    end else if (clk_en_in) begin
      if (!init_done_reg) begin
        divider_select_reg <= fuse_in.initial_divide_by_eight ?
          csp_pkg::DIV_RST_DIV8 : csp_pkg::DIV_RST_NODIV; // [R22]
      end else if (wr_div && !pwdata[csp_pkg::UNLOCK_BIT]) begin
        if (unlock_reg) begin
          divider_select_reg <= pwdata[3:0]; // [R20]
          unlock_reg <= 1'b0; // [R19]
        end
      end else if (wr_div && pwdata[7:0] == csp_pkg::UNLOCK_WORD &&
                   !unlock_reg) begin
        unlock_reg <= 1'b1; // [R18]
        unlock_cnt_reg <= csp_pkg::UNLOCK_CYC - 3'h1;
      end else if (unlock_reg) begin
        if (unlock_cnt_reg == 3'h0) begin
          unlock_reg <= 1'b0; // [R19]
        end else begin
          unlock_cnt_reg <= unlock_cnt_reg - 3'h1;
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Prescaler; new setting taken only at a period boundary

  always_ff @(posedge ref_clk_in or posedge reset_in) begin
    if (reset_in) begin
      cnt_reg <= 8'h00;
      act_sel_reg <= csp_pkg::DIV_RST_NODIV;
    end else if (clk_en_in) begin
      if (tick_now) begin
        cnt_reg <= 8'h00; // [R09]
        act_sel_reg <= divider_select_reg; // [R08]
      end else begin
        cnt_reg <= cnt_reg + 8'h01;
      end
    end
  end

  // Pending covers the end of the old period, busy one whole new period
  always_ff @(posedge ref_clk_in or posedge reset_in) begin
    if (reset_in) begin
      sw_pend_reg <= 1'b0;
      sw_busy_reg <= 1'b0;
    end else if (clk_en_in) begin
      if (tick_now && sw_pend_reg) begin
        sw_pend_reg <= 1'b0; // [R10]
        sw_busy_reg <= 1'b1;
      end else if (tick_now) begin
        sw_busy_reg <= 1'b0; // [R10]
      end
      if (wr_div && unlock_reg && !pwdata[csp_pkg::UNLOCK_BIT]) begin
        sw_pend_reg <= 1'b1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Clock enable, clock-out pin and source status

  always_ff @(posedge ref_clk_in or posedge reset_in) begin
    if (reset_in) begin
      sys_clk_en_out <= 1'b0;
      clock_ready_out <= 1'b0;
      clock_out_pin_out <= 1'b0;
      clock_out_pin_oe_out <= 1'b0;
      osc_mode_out <= 3'h0;
      lf_crystal_sel_out <= 1'b0;
      crystal_sel_out <= 1'b0;
    end else if (clk_en_in) begin
      sys_clk_en_out <= tick_now && run; // [R07]
      clock_ready_out <= run;
      if (tick_now && run) begin
        clock_out_pin_out <= !clock_out_pin_out; // [R13]
      end
      clock_out_pin_oe_out <= fuse_in.clock_out_fuse && !src_is_xt; // [R11] [R12]
      osc_mode_out <= src_is_xt ? fuse_in.clock_source_select[3:1] :
                      3'h0; // [R03]
      lf_crystal_sel_out <= src_is_lf; // [R01]
      crystal_sel_out <= src_is_xt;
    end
  end

  assign trim_out = trim_reg;

  ////////////////////////////////////////////////////////////////////////////
  // APB slave: zero wait states, data and error set up in setup phase

  always_ff @(posedge ref_clk_in or posedge reset_in) begin
    if (reset_in) begin
      prdata <= 32'h00000000;
      pready <= 1'b0;
      pslverr <= 1'b0;
    end else if (clk_en_in) begin
      pready <= setup;
      pslverr <= 1'b0;
      prdata <= 32'h00000000;
      if (setup) begin
        case (paddr)
          csp_pkg::ADDR_DIV: prdata <= {24'h000000, unlock_reg, 3'h0,
                                        divider_select_reg};
          csp_pkg::ADDR_TRIM: prdata <= {24'h000000, trim_reg};
          csp_pkg::ADDR_STAT: prdata <= {28'h0000000, src_is_xt,
                                         src_is_lf, sw_busy_reg, run};
          default: pslverr <= 1'b1;
        endcase
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Assertions

  default clocking cb @(posedge ref_clk_in); endclocking
  default disable iff (reset_in);

  sequence s_unlock;
    wr_div && pwdata[7:0] == csp_pkg::UNLOCK_WORD && !unlock_reg &&
      clk_en_in && init_done_reg;
  endsequence

  sequence s_load;
    wr_div && !pwdata[csp_pkg::UNLOCK_BIT] && clk_en_in;
  endsequence

  a_unlock_then_load: assert property ( // [R20]
    s_unlock ##1 (clk_en_in && !wr_div) [*2] ##1 s_load |=>
      divider_select_reg == $past(pwdata[3:0]) && !unlock_reg)
    else $error("divider not loaded after unlock");

  a_unlock_needs_zeros: assert property ( // [R18]
    wr_div && pwdata[7] && pwdata[6:0] != 7'h00 && !unlock_reg &&
      clk_en_in |=> !unlock_reg)
    else $error("unlock set by a write with other bits high");

  a_unlock_timeout: assert property ( // [R19]
    s_unlock ##1 (clk_en_in && !wr_div) [*4] |=> !unlock_reg)
    else $error("unlock window not closed after four cycles");

  a_div_locked: assert property ( // [R18]
    wr_div && !pwdata[7] && !unlock_reg && init_done_reg |=>
      $stable(divider_select_reg))
    else $error("divider changed without unlock");

  a_div_reset: assert property ( // [R22]
    $rose(init_done_reg) |-> divider_select_reg ==
      (fuse_in.initial_divide_by_eight ? 4'h3 : 4'h0))
    else $error("divider reset value wrong");

  a_switch_edge: assert property ( // [R08]
    !$stable(act_sel_reg) |-> cnt_reg == 8'h00 && $past(tick_now))
    else $error("divider switched inside a period");

  a_busy_two_ticks: assert property ( // [R10]
    $rose(sw_busy_reg) |-> $past(tick_now) && !sw_pend_reg)
    else $error("switch window started off a boundary");

  a_no_xtal_clock_out_pin: assert property ( // [R12]
    src_is_xt |=> !clock_out_pin_oe_out)
    else $error("clock output enabled with crystal source");

  a_trim_load: assert property ( // [R14]
    !init_done_reg && clk_en_in |=> trim_out == $past(factory_trim_in))
    else $error("factory trim not loaded");

  a_hold_startup: assert property ( // [R23]
    !run |=> !sys_clk_en_out)
    else $error("system clock released during start-up");

  a_apb_answer: assert property (
    setup && clk_en_in && paddr != csp_pkg::ADDR_DIV &&
      paddr != csp_pkg::ADDR_TRIM && paddr != csp_pkg::ADDR_STAT
      |=> pready && pslverr)
    else $error("unmapped access not flagged");

endmodule

// [csp_clock_ctrl_test.sv]
// Self-checking testbench of the clock source, start-up and prescaler block.
// Assumes static fuses; each APB transfer waits for pready.
`timescale 1ns/1ps

module csp_clock_ctrl_test;
  localparam int SH = 20;
  localparam int LG = 40;
  logic ref_clk_in, reset_in, clk_en_in, power_down_in;
  csp_pkg::csp_fuse_t fuse_in;
  logic [7:0] factory_trim_in;
  logic psel, penable, pwrite, pready, pslverr;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd_data;
  logic sys_clk_en_out, clock_ready_out, clock_out_pin_out;
  logic clock_out_pin_oe_out, lf_crystal_sel_out, crystal_sel_out, rd_err;
  logic [7:0] trim_out;
  logic [2:0] osc_mode_out;
  logic [3:0] md;
  logic p;
  int bad_count, cmp_count, n, g, f, prev;

  csp_clock_ctrl #(.DELAY_SHORT_CYC_P(SH), .DELAY_LONG_CYC_P(LG)) dut (
    .ref_clk_in, .reset_in, .clk_en_in, .fuse_in, .factory_trim_in,
    .power_down_in, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
    .pready, .pslverr, .sys_clk_en_out, .clock_ready_out,
    .clock_out_pin_out, .clock_out_pin_oe_out, .trim_out, .osc_mode_out,
    .lf_crystal_sel_out, .crystal_sel_out);

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    ref_clk_in = 1'b0;
    forever #25 ref_clk_in = ~ref_clk_in;
  end

  task automatic summarize();
    $display("Comparisons %0d, mismatches %0d", cmp_count, bad_count);
    if (bad_count == 0 && cmp_count > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      bad_count++;
      $display("Error at %0t: got %h, expected %h", $time, got, exp);
    end
  endtask

  // One APB transfer; answer taken at the rising edge that sees pready
  task automatic xfer(input logic w, input logic [11:0] a,
                      input logic [31:0] d);
    @(posedge ref_clk_in);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge ref_clk_in);
    penable <= 1'b1;
    do begin
      @(posedge ref_clk_in);
    end while (pready !== 1'b1);
    rd_data = prdata;
    rd_err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    xfer(1'b1, a, d);
  endtask

  task automatic rd(input logic [11:0] a, input logic [31:0] e,
                    input logic err);
    xfer(1'b0, a, 32'h0);
    chk(rd_data, e);
    chk({31'h0, rd_err}, {31'h0, err});
  endtask

  task automatic setdiv(input logic [3:0] s);
    wr(csp_pkg::ADDR_DIV, 32'h80);
    wr(csp_pkg::ADDR_DIV, {28'h0, s});
  endtask

  // Cycles until the next system clock pulse, counted at falling edges
  task automatic gap(output int c);
    c = 0;
    do begin
      @(negedge ref_clk_in);
      c++;
    end while (sys_clk_en_out !== 1'b1 && c < 600);
  endtask

  task automatic boot(input csp_pkg::csp_fuse_t fz, input int e);
    @(posedge ref_clk_in);
    reset_in <= 1'b1;
    fuse_in <= fz;
    repeat (5) @(posedge ref_clk_in);
    chk({31'h0, clock_out_pin_oe_out}, 32'h0);
    reset_in <= 1'b0;
    n = 0;
    do begin
      @(negedge ref_clk_in);
      n++;
    end while (clock_ready_out !== 1'b1 && n < 40000);
    chk({31'h0, n >= e - 4 && n <= e + 4}, 32'h1);
  endtask

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    reset_in = 1'b1;
    clk_en_in = 1'b1;
    power_down_in = 1'b0;
    fuse_in = {4'h2, 2'h2, 1'b1, 1'b1};
    factory_trim_in = 8'hA5;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h0;
    pwdata = 32'h0;
    bad_count = 0;
    cmp_count = 0;
    boot({4'h2, 2'h2, 1'b1, 1'b1}, 6 + 14 + LG);
    rd(csp_pkg::ADDR_TRIM, 32'hA5, 1'b0);
    rd(csp_pkg::ADDR_DIV, 32'h03, 1'b0);
    rd(csp_pkg::ADDR_STAT, 32'h1, 1'b0);
    chk({31'h0, clock_out_pin_oe_out}, 32'h1);
    wr(csp_pkg::ADDR_TRIM, 32'h7F);
    rd(csp_pkg::ADDR_TRIM, 32'h7F, 1'b0);
    wr(csp_pkg::ADDR_TRIM, 32'hFFFF_FF80);
    rd(csp_pkg::ADDR_TRIM, 32'h80, 1'b0);
    chk({24'h0, trim_out}, 32'h80);
    rd(12'h100, 32'h0, 1'b1);
    $display("Registers and reset values done");
    wr(csp_pkg::ADDR_DIV, 32'h81);
    wr(csp_pkg::ADDR_DIV, 32'h05);
    rd(csp_pkg::ADDR_DIV, 32'h03, 1'b0);
    setdiv(4'h5);
    rd(csp_pkg::ADDR_DIV, 32'h05, 1'b0);
    wr(csp_pkg::ADDR_DIV, 32'h80);
    rd(csp_pkg::ADDR_DIV, 32'h85, 1'b0);
    rd(csp_pkg::ADDR_DIV, 32'h05, 1'b0);
    wr(csp_pkg::ADDR_DIV, 32'h03);
    wr(csp_pkg::ADDR_DIV, 32'h80);
    wr(csp_pkg::ADDR_DIV, 32'h80);
    wr(csp_pkg::ADDR_DIV, 32'h06);
    rd(csp_pkg::ADDR_DIV, 32'h05, 1'b0);
    $display("Unlock protocol done");
    prev = 32;
    for (int s = 0; s <= 9; s++) begin
      f = (s > 8) ? 256 : (1 << s);
      setdiv(s[3:0]);
      gap(n);
      gap(g);
      chk({31'h0, g >= ((prev < f) ? prev : f)}, 32'h1);
      chk({31'h0, n + g <= prev + 2 * f + 1}, 32'h1);
      gap(g);
      chk(g, f);
      p = clock_out_pin_out;
      gap(g);
      chk({31'h0, clock_out_pin_out}, {31'h0, ~p});
      rd(csp_pkg::ADDR_DIV, {28'h0, s[3:0]}, 1'b0);
      prev = f;
    end
    $display("Divider factors done");
    @(posedge ref_clk_in);
    clk_en_in <= 1'b0;
    @(negedge ref_clk_in);
    p = clock_out_pin_out;
    repeat (300) @(negedge ref_clk_in);
    chk({31'h0, clock_out_pin_out}, {31'h0, p});
    @(posedge ref_clk_in);
    clk_en_in <= 1'b1;
    $display("Clock enable freeze done");
    @(posedge ref_clk_in);
    power_down_in <= 1'b1;
    repeat (4) @(posedge ref_clk_in);
    chk({31'h0, clock_ready_out}, 32'h0);
    power_down_in <= 1'b0;
    n = 0;
    do begin
      @(negedge ref_clk_in);
      n++;
    end while (clock_ready_out !== 1'b1 && n < 100);
    chk({31'h0, n <= 12}, 32'h1);
    $display("Sleep and wake done");
    for (int i = 0; i < 4; i++) begin
      md = 4'h8 + 4'(2 * i);
      boot({md, 2'h0, 1'b0, 1'b1}, 258 + 14 + SH);
      chk({29'h0, osc_mode_out}, {29'h0, md[3:1]});
      chk({30'h0, crystal_sel_out, clock_out_pin_oe_out}, 32'h2);
    end
    boot({4'hF, 2'h0, 1'b0, 1'b1}, 1024 + 14 + LG);
    rd(csp_pkg::ADDR_DIV, 32'h00, 1'b0);
    $display("Crystal modes done");
    boot({4'h4, 2'h0, 1'b0, 1'b0}, 1024 + SH);
    chk({31'h0, lf_crystal_sel_out}, 32'h1);
    rd(csp_pkg::ADDR_STAT, 32'h5, 1'b0);
    boot({4'h4, 2'h2, 1'b0, 1'b0}, 32768 + LG);
    $display("Watch crystal done");
    summarize();
  end

  initial begin
    #4000000;
    bad_count++;
    summarize();
  end
endmodule
